// ==== verilog/sitx_top.sv ====
// static io channels, forced triggers and signal export
`timescale 1ns/1ps
module sitx_top (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // channel pins
    input  wire logic [sitx_pkg::NCH-1:0]   ch_i,
    output logic      [sitx_pkg::NCH-1:0]   ch_o,
    output logic      [sitx_pkg::NCH-1:0]   ch_oe,
    // channel assignment
    input  wire logic                       assign_we,
    input  wire logic [sitx_pkg::NCH-1:0]   static_gen_sel,
    input  wire logic [sitx_pkg::NCH-1:0]   static_acq_sel,
    input  wire logic [sitx_pkg::NCH-1:0]   dyn_gen_sel,
    output logic                            assign_err,
    output logic      [sitx_pkg::NCH-1:0]   static_gen_set,
    output logic      [sitx_pkg::NCH-1:0]   dyn_gen_set,
    // static write and read
    input  wire logic                       static_we,
    input  wire logic [sitx_pkg::NCH-1:0]   static_write_word,
    input  wire logic [sitx_pkg::NCH-1:0]   write_change_mask,
    output logic      [sitx_pkg::NCH-1:0]   static_read_word,
    // tristate override
    input  wire logic                       tri_we,
    input  wire logic [sitx_pkg::NCH-1:0]   tri_sel,
    input  wire logic                       tri_val,
    // dynamic drive from the sequencer
    input  wire logic [sitx_pkg::NCH-1:0]   dyn_data,
    // software and hardware triggers
    input  wire logic                       sw_trig,
    input  wire logic [7:0]                 sw_trig_code,
    input  wire logic [1:0]                 sw_trig_inst,
    input  wire logic                       hw_start,
    input  wire logic                       hw_ref,
    input  wire logic                       hw_adv,
    input  wire logic [3:0]                 hw_seq,
    output logic                            start_trig,
    output logic                            ref_trig,
    output logic                            adv_trig,
    output logic      [3:0]                 seq_trig,
    output logic                            trig_err,
    // signal export
    input  wire logic                       exp_commit,
    input  wire logic [7:0]                 exp_code,
    input  wire logic [1:0]                 exp_inst,
    input  wire logic [sitx_pkg::TW-1:0]    exp_dest,
    input  wire logic                       sclk_lvl,
    input  wire logic                       rclk_lvl,
    input  wire logic                       pause_lvl,
    input  wire logic [3:0]                 marker_lvl,
    input  wire logic                       obrclk_lvl,
    output logic      [sitx_pkg::NTERM-1:0] term_o,
    output logic      [sitx_pkg::NTERM-1:0] term_oe,
    output logic                            exp_err,
    output logic                            exp_changed
);
    sitx_route_if rif ();

    logic [sitx_pkg::NCH-1:0] gen_q, gen_d, acq_q, acq_d, dyn_q, dyn_d;
    logic [sitx_pkg::NCH-1:0] val_q, val_d, tri_q, tri_d;
    logic [sitx_pkg::NCH-1:0] s1_q, s2_q, rd_q, rd_d;
    logic [sitx_pkg::NCH-1:0] o_q, o_d, oe_q, oe_d;
    logic                     aerr_q, aerr_d;
    logic                     st_q, st_d, rt_q, rt_d, at_q, at_d, te_q, te_d;
    logic [3:0]               sq_q, sq_d;
    logic                     eerr_q, eerr_d, ecmt_q, ecmt_d;
    logic                     rej_q, rej_d;
    logic [2:0]               esel_q, esel_d;
    logic [sitx_pkg::TW-1:0]  edst_q, edst_d;
    logic [sitx_pkg::NSRC-1:0] src_q, src_d;
    sitx_pkg::sitx_cst_t      cst_q, cst_d;

    // map an export source code to its router slot
    function automatic logic [3:0] src_slot(input logic [7:0] code,
                                            input logic [1:0] inst);
        logic [3:0] r;
        r = 4'hf;
        if (code == sitx_pkg::SRC_SCLK) begin
            r = 4'h0;
        end else if (code == sitx_pkg::SRC_RCLK) begin
            r = 4'h1;
        end else if (code == sitx_pkg::SRC_PAUSE) begin
            r = 4'h2;
        end else if (code == sitx_pkg::SRC_MARKER) begin
            r = 4'h3 + {2'b00, inst};
        end else if (code == sitx_pkg::SRC_OBRCLK) begin
            r = 4'h7;
        end
        return r;
    endfunction

    // channel assignment
    always_comb begin
        gen_d  = gen_q;
        acq_d  = acq_q;
        dyn_d  = dyn_q;
        aerr_d = 1'b0;
        if (assign_we) begin
            // refuse overlap of static and dynamic generation
            if ((static_gen_sel & dyn_gen_sel) != sitx_pkg::ZERO_CH) begin
                aerr_d = 1'b1;
            end else begin
                gen_d = static_gen_sel;
                acq_d = static_acq_sel;
                dyn_d = dyn_gen_sel;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gen_q  <= '0;
            acq_q  <= '0;
            dyn_q  <= '0;
            aerr_q <= 1'b0;
        end else begin
            gen_q  <= gen_d;
            acq_q  <= acq_d;
            dyn_q  <= dyn_d;
            aerr_q <= aerr_d;
        end
    end

    // static output value, override and drivers
    always_comb begin
        val_d = val_q;
        // masked update, bit 0 is channel 0, next edge
        if (static_we) begin
            val_d = (val_q & ~write_change_mask)
                  | (static_write_word & write_change_mask);
        end
        tri_d = tri_q;
        // override set and cleared only explicitly
        if (tri_we) begin
            tri_d = tri_val ? (tri_q | tri_sel) : (tri_q & ~tri_sel);
        end
        // stored value drives high or low; others untouched
        // override disables driver, value kept for release
        o_d  = (gen_q & val_q) | (dyn_q & dyn_data);
        oe_d = (gen_q | dyn_q) & ~tri_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            val_q <= '0;
            tri_q <= '0;
            o_q   <= '0;
            oe_q  <= '0; // all channels tristate
        end else begin
            val_q <= val_d;
            tri_q <= tri_d;
            o_q   <= o_d;
            oe_q  <= oe_d;
        end
    end

    // pin synchroniser and read word
    always_comb begin
        // synchronised level of static-acquire channels only
        rd_d = s2_q & acq_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            rd_q <= '0;
        end else begin
            s1_q <= ch_i;
            s2_q <= s1_q;
            rd_q <= rd_d;
        end
    end

    // forced triggers: one-cycle pulse ORed with detector
    always_comb begin
        st_d = hw_start;
        rt_d = hw_ref;
        at_d = hw_adv;
        sq_d = hw_seq;
        te_d = 1'b0;
        if (sw_trig) begin
            if (sw_trig_code == sitx_pkg::TRIG_START) begin
                st_d = 1'b1;
            end else if (sw_trig_code == sitx_pkg::TRIG_REF) begin
                rt_d = 1'b1;
            end else if (sw_trig_code == sitx_pkg::TRIG_SEQ) begin
                sq_d[sw_trig_inst] = 1'b1;
            end else if (sw_trig_code == sitx_pkg::TRIG_ADV) begin
                at_d = 1'b1;
            end else begin
                te_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= 1'b0;
            rt_q <= 1'b0;
            at_q <= 1'b0;
            sq_q <= '0;
            te_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rt_q <= rt_d;
            at_q <= at_d;
            sq_q <= sq_d;
            te_q <= te_d;
        end
    end

    // export command decode toward the router
    always_comb begin
        logic [3:0] slot;
        slot   = src_slot(exp_code, exp_inst);
        cst_d  = sitx_pkg::SITX_IDLE;
        ecmt_d = 1'b0;
        esel_d = esel_q;
        edst_d = edst_q;
        eerr_d = rif.err | rej_q;
        rej_d  = 1'b0;
        case (cst_q)
            sitx_pkg::SITX_IDLE: begin
                if (exp_commit) begin
                    if (slot == 4'hf) begin
                        cst_d = sitx_pkg::SITX_REJECT;
                    end else begin
                        cst_d  = sitx_pkg::SITX_APPLY;
                        ecmt_d = 1'b1;
                        esel_d = slot[2:0];
                        edst_d = exp_dest;
                    end
                end
            end
            sitx_pkg::SITX_APPLY: begin
                cst_d = sitx_pkg::SITX_IDLE;
            end
            sitx_pkg::SITX_REJECT: begin
                // delayed one cycle to line up with the router error
                rej_d = 1'b1;
            end
            default: begin
                cst_d = sitx_pkg::SITX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cst_q  <= sitx_pkg::SITX_IDLE;
            ecmt_q <= 1'b0;
            esel_q <= '0;
            edst_q <= sitx_pkg::TERM_NONE;
            eerr_q <= 1'b0;
            rej_q  <= 1'b0;
        end else begin
            cst_q  <= cst_d;
            ecmt_q <= ecmt_d;
            esel_q <= esel_d;
            edst_q <= edst_d;
            eerr_q <= eerr_d;
            rej_q  <= rej_d;
        end
    end

    // export source levels, one register stage
    always_comb begin
        src_d = {obrclk_lvl, marker_lvl, pause_lvl, rclk_lvl, sclk_lvl};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_q <= '0;
        end else begin
            src_q <= src_d;
        end
    end

    assign rif.src_lvl = src_q;
    assign rif.commit  = ecmt_q;
    assign rif.sel     = esel_q;
    assign rif.dest    = edst_q;

    sitx_router u_rtr (
        .clk    (clk),
        .arst_n (arst_n),
        .rif    (rif)
    );

    assign ch_o             = o_q;
    assign ch_oe            = oe_q;
    assign assign_err       = aerr_q;
    assign static_gen_set   = gen_q;
    assign dyn_gen_set      = dyn_q;
    assign static_read_word = rd_q;
    assign start_trig       = st_q;
    assign ref_trig         = rt_q;
    assign adv_trig         = at_q;
    assign seq_trig         = sq_q;
    assign trig_err         = te_q;
    assign term_o           = rif.term_o;
    assign term_oe          = rif.term_oe;
    assign exp_err          = eerr_q;
    assign exp_changed      = rif.busy;
endmodule

// ==== verilog/sitx_pkg.sv ====
// constants and types for the static io, trigger and export block
// Behaviour
// - a channel is never in both static and dynamic generation
// - static read gives synced levels of static-acquire channels, else 0
// - bit 0 of read, write and mask words is the lowest channel
// - write bit one drives a static channel high, zero drives it low
// - write bits of non-static-generation channels do not affect them
// - mask one updates the channel from the write word, zero keeps it
// - tristated static channel stores writes but keeps its driver off
// - releasing tristate drives the last value written, even during tristate
// - software command forces one start, reference, advance or script trigger
// - trigger codes 53 start, 54 reference, 58 script with four instances
// - forced advance trigger code is 61, acquisition only
// - export routes persist past session close; reset or a commit to no destination removes them
// - moving an export retristates the old terminal at commit
// - selecting no destination tristates the old terminal at commit
// - export sources: sample clock 51, ref clock 52, pause 57, markers
// - backplane line 7 only carries onboard reference clock, else error
// - commit programs only settings changed since the previous commit
// - reset tristates all, restores initial settings, releases all routes
// - tristate override holds the channel undriven until explicitly cleared
package sitx_pkg;
    localparam int          NCH        = 32;
    localparam int          NTERM      = 16;
    localparam int          TW         = 4;
    localparam int          NSRC       = 8;
    localparam logic [7:0]  TRIG_START = 8'h35;
    localparam logic [7:0]  TRIG_REF   = 8'h36;
    localparam logic [7:0]  TRIG_SEQ   = 8'h3a;
    localparam logic [7:0]  TRIG_ADV   = 8'h3d;
    localparam logic [7:0]  SRC_SCLK   = 8'h33;
    localparam logic [7:0]  SRC_RCLK   = 8'h34;
    localparam logic [7:0]  SRC_PAUSE  = 8'h39;
    localparam logic [7:0]  SRC_MARKER = 8'h3b;
    localparam logic [7:0]  SRC_OBRCLK = 8'h3e;
    localparam logic [3:0]  TERM_BP7   = 4'h8;
    localparam logic [3:0]  TERM_NONE  = 4'hf;
    localparam logic [NCH-1:0] ZERO_CH = '0;
    typedef enum logic [1:0] {
        SITX_IDLE   = 2'b00,
        SITX_APPLY  = 2'b01,
        SITX_REJECT = 2'b10
    } sitx_cst_t;
endpackage

// ==== verilog/sitx_route_if.sv ====
// signals between the export router and the top
`timescale 1ns/1ps
interface sitx_route_if;
    logic [sitx_pkg::NSRC-1:0] src_lvl;
    logic [sitx_pkg::NTERM-1:0] term_o;
    logic [sitx_pkg::NTERM-1:0] term_oe;
    logic                       commit;
    logic [2:0]                 sel;
    logic [sitx_pkg::TW-1:0]    dest;
    logic                       busy;
    logic                       err;
    modport rtr (input src_lvl, commit, sel, dest,
                 output term_o, term_oe, busy, err);
    modport top (output src_lvl, commit, sel, dest,
                 input term_o, term_oe, busy, err);
endinterface

// ==== verilog/sitx_router.sv ====
// export router: committed routes of sources onto terminals
`timescale 1ns/1ps
module sitx_router (
    input  wire logic clk,
    input  wire logic arst_n,
    sitx_route_if.rtr rif
);
    logic [sitx_pkg::TW-1:0] dst_q [sitx_pkg::NSRC];
    logic [sitx_pkg::TW-1:0] dst_d [sitx_pkg::NSRC];
    logic [sitx_pkg::NTERM-1:0] o_q, o_d, oe_q, oe_d;
    logic                       err_q, err_d;
    logic                       ch_q, ch_d;

    always_comb begin
        dst_d = dst_q;
        err_d = 1'b0;
        ch_d  = 1'b0;
        if (rif.commit) begin
            // line 7 of the backplane only for onboard ref clock
            if (rif.dest == sitx_pkg::TERM_BP7 && rif.sel != 3'd7) begin
                err_d = 1'b1;
            end else if (dst_q[rif.sel] != rif.dest) begin
                // only a changed setting is programmed
                dst_d[rif.sel] = rif.dest;
                ch_d = 1'b1;
            end
        end
    end

    always_comb begin
        o_d  = '0;
        oe_d = '0;
        // vacated or unselected terminals fall back to tristate
        for (int s = 0; s < sitx_pkg::NSRC; s++) begin
            if (dst_q[s] != sitx_pkg::TERM_NONE) begin
                oe_d[dst_q[s]] = 1'b1;
                o_d[dst_q[s]]  = rif.src_lvl[s];
            end
        end
    end

    // routes persist until reset or a new commit for their source
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int s = 0; s < sitx_pkg::NSRC; s++) begin
                dst_q[s] <= sitx_pkg::TERM_NONE;
            end
            o_q   <= '0;
            oe_q  <= '0;
            err_q <= 1'b0;
            ch_q  <= 1'b0;
        end else begin
            dst_q <= dst_d;
            o_q   <= o_d;
            oe_q  <= oe_d;
            err_q <= err_d;
            ch_q  <= ch_d;
        end
    end

    assign rif.term_o  = o_q;
    assign rif.term_oe = oe_q;
    assign rif.err     = err_q;
    assign rif.busy    = ch_q;
endmodule

// ==== sim/sitx_chk.sv ====
// assertions on the top ports of the static io block
`timescale 1ns/1ps
module sitx_chk (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       arst_n,
    // channels
    input wire logic [sitx_pkg::NCH-1:0]   ch_o,
    input wire logic [sitx_pkg::NCH-1:0]   ch_oe,
    input wire logic                       assign_we,
    input wire logic [sitx_pkg::NCH-1:0]   static_gen_sel,
    input wire logic [sitx_pkg::NCH-1:0]   dyn_gen_sel,
    input wire logic                       assign_err,
    input wire logic [sitx_pkg::NCH-1:0]   static_gen_set,
    input wire logic [sitx_pkg::NCH-1:0]   dyn_gen_set,
    input wire logic                       static_we,
    input wire logic [sitx_pkg::NCH-1:0]   static_write_word,
    input wire logic [sitx_pkg::NCH-1:0]   write_change_mask,
    input wire logic                       tri_we,
    input wire logic [sitx_pkg::NCH-1:0]   tri_sel,
    input wire logic                       tri_val,
    // triggers and export
    input wire logic                       sw_trig,
    input wire logic [7:0]                 sw_trig_code,
    input wire logic                       hw_ref,
    input wire logic                       hw_adv,
    input wire logic                       start_trig,
    input wire logic                       ref_trig,
    input wire logic                       adv_trig,
    input wire logic                       exp_commit,
    input wire logic [7:0]                 exp_code,
    input wire logic [sitx_pkg::TW-1:0]    exp_dest,
    input wire logic                       exp_err,
    input wire logic [sitx_pkg::NTERM-1:0] term_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_wr_alone;
        static_we ##1 !static_we;
    endsequence
    sequence s_adv_once;
        (sw_trig && sw_trig_code == sitx_pkg::TRIG_ADV)
        ##1 (!sw_trig && !hw_adv);
    endsequence
    a_sets_apart: assert property (
        (static_gen_set & dyn_gen_set) == '0)
        else $error("channel in both generation sets");
    a_overlap_refused: assert property (assign_we &&
        (static_gen_sel & dyn_gen_sel) != '0 |=> assign_err &&
        $stable(static_gen_set))
        else $error("overlapping assignment not refused");
    a_write_drives: assert property (s_wr_alone |=>
        (((ch_o ^ $past(static_write_word, 2)) & $past(write_change_mask, 2)
        & static_gen_set & ch_oe) == '0))
        else $error("static write not driven");
    a_tri_undriven: assert property (tri_we && tri_val |->
        ##2 ((ch_oe & $past(tri_sel, 2)) == '0))
        else $error("override channel still driven");
    a_start_forced: assert property (sw_trig &&
        sw_trig_code == sitx_pkg::TRIG_START |=> start_trig)
        else $error("forced start missing");
    a_adv_pulse: assert property (s_adv_once |=> !adv_trig)
        else $error("forced advance longer than one clock");
    a_hw_or_ref: assert property (hw_ref |=> ref_trig)
        else $error("hardware reference not passed");
    a_line7_guard: assert property (exp_commit &&
        exp_dest == sitx_pkg::TERM_BP7 && exp_code != sitx_pkg::SRC_OBRCLK
        |-> ##3 exp_err)
        else $error("line seven misuse not flagged");
    a_reset_off: assert property ($rose(arst_n) |->
        ch_oe == '0 && term_oe == '0)
        else $error("drivers on after reset");
endmodule
bind sitx_top sitx_chk u_sitx_chk (.*);

// ==== sim/sitx_ext_model.sv ====
// external circuit attached to the channel pins
`timescale 1ns/1ps
module sitx_ext_model (
    input  wire logic [sitx_pkg::NCH-1:0] ch_o,
    input  wire logic [sitx_pkg::NCH-1:0] ch_oe,
    input  wire logic [sitx_pkg::NCH-1:0] ext_val,
    output logic      [sitx_pkg::NCH-1:0] ch_i
);
    // pin follows the device where driven, else the outside level
    assign ch_i = (ch_o & ch_oe) | (ext_val & ~ch_oe);
endmodule

// ==== sim/sitx_top_tb.sv ====
// self-checking bench for the static io, trigger and export block
`timescale 1ns/1ps
module sitx_top_tb;
    logic clk, arst_n, assign_we, assign_err, static_we, tri_we, tri_val;
    logic [31:0] ch_i, ch_o, ch_oe, ext_val, static_gen_sel, static_acq_sel;
    logic [31:0] dyn_gen_sel, static_gen_set, dyn_gen_set, dyn_data;
    logic [31:0] static_write_word, write_change_mask, static_read_word;
    logic [31:0] tri_sel;
    logic sw_trig, hw_start, hw_ref, hw_adv, start_trig, ref_trig, adv_trig;
    logic trig_err, exp_commit, sclk_lvl, rclk_lvl, pause_lvl, obrclk_lvl;
    logic exp_err, exp_changed;
    logic [7:0] sw_trig_code, exp_code;
    logic [1:0] sw_trig_inst, exp_inst;
    logic [3:0] hw_seq, seq_trig, marker_lvl, exp_dest;
    logic [15:0] term_o, term_oe;
    int n_fail, n_compared;
    sitx_top u_sitx_top (.*);
    sitx_ext_model u_sitx_ext_model (.ch_o(ch_o), .ch_oe(ch_oe),
        .ext_val(ext_val), .ch_i(ch_i));
    always #4 clk = ~clk;
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(logic [31:0] w, logic [31:0] m);
        static_write_word = w;
        write_change_mask = m;
        static_we = 1;
        tick();
        static_we = 0;
        tick();
    endtask
    function automatic logic [31:0] tv();
        return {24'h0, trig_err, adv_trig, ref_trig, start_trig, seq_trig};
    endfunction
    task automatic trig(logic [7:0] c, logic [1:0] i, logic [7:0] e);
        sw_trig_code = c;
        sw_trig_inst = i;
        sw_trig = 1;
        tick();
        sw_trig = 0;
        chk(tv(), {24'h0, e}, "forced trigger");
        tick();
        chk(tv(), 0, "trigger pulse end");
    endtask
    task automatic xp(logic [7:0] c, logic [1:0] i, logic [3:0] d,
                      logic err, logic chg, logic [15:0] oe);
        logic e, g;
        e = 0;
        g = 0;
        exp_code = c;
        exp_inst = i;
        exp_dest = d;
        exp_commit = 1;
        tick();
        exp_commit = 0;
        repeat (4) begin
            e |= exp_err;
            g |= exp_changed;
            tick();
        end
        chk({31'h0, e}, {31'h0, err}, "export error");
        chk({31'h0, g}, {31'h0, chg}, "export changed");
        chk({16'h0, term_oe}, {16'h0, oe}, "terminal enables");
    endtask
    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial begin
        {clk, arst_n, assign_we, static_we, tri_we, tri_val, sw_trig} = '0;
        {hw_start, hw_ref, hw_adv, hw_seq, exp_commit, sclk_lvl} = '0;
        {rclk_lvl, pause_lvl, obrclk_lvl, marker_lvl, exp_dest} = '0;
        {sw_trig_code, exp_code, sw_trig_inst, exp_inst} = '0;
        {ext_val, static_gen_sel, static_acq_sel, dyn_gen_sel} = '0;
        {static_write_word, write_change_mask, tri_sel} = '0;
        n_fail = 0;
        n_compared = 0;
        dyn_data = 32'h0000_3c00;
        repeat (5) @(posedge clk);
        #1 arst_n = 1;
        chk(ch_oe, 0, "channel enables after reset");
        static_gen_sel = 32'h0000_00ff;
        static_acq_sel = 32'hffff_0000;
        dyn_gen_sel = 32'h0000_ff00;
        assign_we = 1;
        tick();
        assign_we = 0;
        tick();
        chk(static_gen_set, 32'h0000_00ff, "static set");
        dyn_gen_sel = 32'h0000_ff01;
        assign_we = 1;
        tick();
        assign_we = 0;
        chk({31'h0, assign_err}, 1, "overlap flag");
        tick();
        chk(dyn_gen_set, 32'h0000_ff00, "dynamic set kept");
        wr(32'h0000_ffa5, 32'h0000_ff0f);
        chk(ch_o & 32'hffff, 32'h3c05, "masked write");
        chk(ch_oe & 32'hff, 32'hff, "static enables");
        wr(32'h0000_0080, 32'h0000_0080);
        chk(ch_o & 32'hff, 32'h85, "single bit write");
        ext_val = 32'h5a3c_0000;
        tick(2);
        chk(static_read_word, 0, "read before sync");
        tick(2);
        chk(static_read_word, 32'h5a3c_0000, "read word");
        tri_sel = 32'h0000_000f;
        tri_val = 1;
        tri_we = 1;
        tick();
        tri_we = 0;
        wr(32'h0000_000a, 32'h0000_000f);
        chk(ch_oe & 32'hff, 32'hf0, "override holds off");
        tri_val = 0;
        tri_we = 1;
        tick();
        tri_we = 0;
        tick();
        chk(ch_oe & 32'hff, 32'hff, "override released");
        chk(ch_o & 32'hff, 32'h8a, "value kept under override");
        for (int i = 0; i < 4; i++)
            trig(sitx_pkg::TRIG_SEQ, 2'(i), 8'h01 << i);
        trig(sitx_pkg::TRIG_START, 2'h0, 8'h10);
        trig(sitx_pkg::TRIG_REF, 2'h0, 8'h20);
        trig(sitx_pkg::TRIG_ADV, 2'h0, 8'h40);
        trig(8'h00, 2'h0, 8'h80);
        hw_ref = 1;
        tick();
        hw_ref = 0;
        chk(tv(), 32'h20, "hardware reference");
        pause_lvl = 1;
        rclk_lvl = 1;
        marker_lvl = 4'b0100;
        xp(sitx_pkg::SRC_SCLK, 2'h0, 4'h2, 0, 1, 16'h0004);
        xp(sitx_pkg::SRC_SCLK, 2'h0, 4'h3, 0, 1, 16'h0008);
        xp(sitx_pkg::SRC_SCLK, 2'h0, 4'h3, 0, 0, 16'h0008);
        xp(sitx_pkg::SRC_SCLK, 2'h0, sitx_pkg::TERM_NONE, 0, 1, 0);
        xp(sitx_pkg::SRC_RCLK, 2'h0, sitx_pkg::TERM_BP7, 1, 0, 0);
        xp(sitx_pkg::SRC_OBRCLK, 2'h0, sitx_pkg::TERM_BP7,
           0, 1, 16'h0100);
        xp(sitx_pkg::SRC_PAUSE, 2'h0, 4'h5, 0, 1, 16'h0120);
        xp(sitx_pkg::SRC_MARKER, 2'h2, 4'h6, 0, 1, 16'h0160);
        xp(sitx_pkg::SRC_RCLK, 2'h0, 4'h7, 0, 1, 16'h01e0);
        xp(8'h00, 2'h0, 4'h2, 1, 0, 16'h01e0);
        chk({16'h0, term_o & term_oe}, 32'h00e0, "exported levels");
        tick(8);
        chk({16'h0, term_oe}, 32'h01e0, "routes persist");
        arst_n = 0;
        #2;
        chk(ch_oe, 0, "channels off in reset");
        chk({16'h0, term_oe}, 0, "terminals off in reset");
        tick();
        arst_n = 1;
        tick();
        chk(static_gen_set, 0, "sets cleared");
        test_done();
    end
endmodule
